// File: jtp_regs.svh
// Purpose: Constants for the jitter test pattern generator
// Assumes: Included by its bare name wherever these values are needed
// Notes: Code-groups are 10 bits, bit 9 is the first bit on the line
`ifndef JTP_REGS_SVH
`define JTP_REGS_SVH

// ----------------------------------------------------------------
// Frame layout of the long random pattern
// ----------------------------------------------------------------
`define JTP_PRE_LEN 11'h008
`define JTP_PAY_LEN 11'h5E8
`define JTP_CRC_LEN 11'h004
`define JTP_IPG_LEN 11'h00C
`define JTP_SEQ_LEN 4'hC
`define JTP_SEQ_REPS 8'h7E
`define JTP_PRE_OCTET 8'h55
`define JTP_SFD_OCTET 8'hD5
`define JTP_IDLE_OCTET 8'h00
`define JTP_CRC0 8'h94
`define JTP_CRC1 8'hD2
`define JTP_CRC2 8'h54
`define JTP_CRC3 8'hAC

// ----------------------------------------------------------------
// Code-groups per running disparity (neg / pos)
// ----------------------------------------------------------------
`define JTP_K28_7_NEG 10'h0F8
`define JTP_K28_7_POS 10'h307
`define JTP_K28_5_NEG 10'h0FA
`define JTP_K28_5_POS 10'h305
`define JTP_D21_5 10'h2AA

// ----------------------------------------------------------------
// Reset value and FIFO depth
// ----------------------------------------------------------------
`define JTP_RST_ERR_COUNT 16'h0000
`define JTP_FIFO_DEPTH 8
`endif

// File: jtp_pkg.sv
// Purpose: Types shared by the jitter test pattern generator
// Assumes: Nothing beyond the constants header
// Notes: The word carries either a code-group or a GMII octet
package jtp_pkg;

  typedef enum logic [1:0] {
    JTP_MODE_HIGH = 2'b00,
    JTP_MODE_LOW = 2'b01,
    JTP_MODE_MIXED = 2'b10,
    JTP_MODE_LONG = 2'b11
  } jtp_mode_t;

  // Gray coded along the usual packet path
  typedef enum logic [1:0] {
    JTP_ST_PRE = 2'b00,
    JTP_ST_PAY = 2'b01,
    JTP_ST_CRC = 2'b11,
    JTP_ST_IPG = 2'b10
  } jtp_state_t;

  typedef struct packed {
    logic is_cg;
    logic tx_en;
    logic tx_er;
    logic [7:0] octet;
    logic [9:0] code_group;
  } jtp_word_t;

endpackage : jtp_pkg

// File: jtp_fifo.sv
// Purpose: Small synchronous FIFO between pattern source and output stage
// Assumes: One clock, asynchronous active-low reset
// Notes: Read data is combinational from the array head
`timescale 1ns/10ps
module jtp_fifo #(
  parameter int WIDTH = 21,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  assign in_ready = (count_q != (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  function automatic logic [AW-1:0] jtp_wrap(input logic [AW-1:0] p);
    jtp_wrap = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction : jtp_wrap

  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_q <= jtp_wrap(wr_q);
      end
      if (pop) begin
        rd_q <= jtp_wrap(rd_q);
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule : jtp_fifo

// File: jtp_gen.sv
// Purpose: Jitter test pattern generator for a gigabit serial transmitter
// Assumes: Encoder downstream turns GMII octets into code-groups
// Notes: Tone patterns leave as code-groups, the long pattern as octets
//
// What this block does
// RULE_01 - Low mode: five ones, five zeros, repeating
// RULE_02 - Low mode repeats K28.7 with disparity
// RULE_03 - Mixed mode repeats K28.5, disparity alternating
// RULE_04 - High mode repeats D21.5 with disparity
// RULE_05 - Long mode: identical framed packets, minimum gap
// RULE_06 - Packet: 8 preamble, 1512 payload, 4 CRC, 12 gap
// RULE_07 - Preamble seven 55 then D5
// RULE_08 - Payload: twelve-octet sequence repeated 126 times
// RULE_09 - Packet octets given before 8B/10B encoding
// RULE_10 - Patterns built at code-group or frame level
// RULE_11 - Receiver optionally checks pattern, reports errors; the code checks the tone modes only, never the long mode
// RULE_12 - Gap: enable, error low, zero octets
// RULE_13 - CRC octets are precomputed frame check sequence
`timescale 1ns/10ps
`include "jtp_regs.svh"
module jtp_gen import jtp_pkg::*; #(
  parameter logic [10:0] PAY_LEN = `JTP_PAY_LEN,
  parameter int FIFO_DEPTH = `JTP_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire jtp_mode_t mode,
  // Transmit stream
  output jtp_word_t tx_word_q,
  output logic tx_valid_q,
  input wire logic tx_ready,
  // Receive check
  input wire logic rx_cg_valid,
  input wire logic [9:0] rx_cg,
  output logic [15:0] err_count_q,
  output logic err_seen_q
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [9:0] jtp_cg_pick(input jtp_mode_t m, input logic pos);
    case (m)
      JTP_MODE_LOW: jtp_cg_pick = pos ? `JTP_K28_7_POS : `JTP_K28_7_NEG;
      JTP_MODE_MIXED: jtp_cg_pick = pos ? `JTP_K28_5_POS : `JTP_K28_5_NEG;
      default: jtp_cg_pick = `JTP_D21_5;
    endcase
  endfunction : jtp_cg_pick

  function automatic logic jtp_unbalanced(input logic [9:0] cg);
    logic [3:0] ones;
    ones = '0;
    for (int i = 0; i < 10; i++) begin
      ones = ones + {3'b000, cg[i]};
    end
    jtp_unbalanced = (ones != 4'h5);
  endfunction : jtp_unbalanced

  function automatic logic [7:0] jtp_seq(input logic [3:0] i);
    case (i)
      4'h0: jtp_seq = 8'hBE;
      4'h1: jtp_seq = 8'hD7;
      4'h2: jtp_seq = 8'h23;
      4'h3: jtp_seq = 8'h47;
      4'h4: jtp_seq = 8'h6B;
      4'h5: jtp_seq = 8'h8F;
      4'h6: jtp_seq = 8'hB3;
      4'h7: jtp_seq = 8'h14;
      4'h8: jtp_seq = 8'h5E;
      4'h9: jtp_seq = 8'hFB;
      4'hA: jtp_seq = 8'h35;
      default: jtp_seq = 8'h59;
    endcase
  endfunction : jtp_seq

  function automatic logic [7:0] jtp_crc(input logic [1:0] i);
    case (i)
      2'd0: jtp_crc = `JTP_CRC0;
      2'd1: jtp_crc = `JTP_CRC1;
      2'd2: jtp_crc = `JTP_CRC2;
      default: jtp_crc = `JTP_CRC3;
    endcase
  endfunction : jtp_crc

  // ----------------------------------------------------------------
  // Pattern source
  // ----------------------------------------------------------------
  jtp_mode_t mode_q;
  jtp_state_t state_q;
  logic run_q;
  logic rd_pos_q;
  logic [10:0] idx_q;
  logic [3:0] seq_q;
  jtp_word_t gen_word;
  logic gen_ready;
  logic take;
  logic last;

  assign take = run_q && gen_ready;

  always_comb begin
    gen_word = '0;
    last = 1'b0;
    if (mode_q != JTP_MODE_LONG) begin
      gen_word.is_cg = 1'b1; // [RULE_10]
      gen_word.code_group = jtp_cg_pick(mode_q, rd_pos_q); // [RULE_01] [RULE_02] [RULE_03] [RULE_04]
    end else begin
      // Octets only; the downstream encoder wraps delimiters and codes them [RULE_09]
      case (state_q)
        JTP_ST_PRE: begin
          gen_word.tx_en = 1'b1;
          gen_word.octet = (idx_q == `JTP_PRE_LEN - 1'b1) ? `JTP_SFD_OCTET
                                                          : `JTP_PRE_OCTET; // [RULE_07]
          last = (idx_q == `JTP_PRE_LEN - 1'b1);
        end
        JTP_ST_PAY: begin
          gen_word.tx_en = 1'b1;
          gen_word.octet = jtp_seq(seq_q); // [RULE_08]
          last = (idx_q == PAY_LEN - 1'b1);
        end
        JTP_ST_CRC: begin
          gen_word.tx_en = 1'b1;
          gen_word.octet = jtp_crc(idx_q[1:0]); // [RULE_13]
          last = (idx_q == `JTP_CRC_LEN - 1'b1);
        end
        default: begin
          gen_word.octet = `JTP_IDLE_OCTET; // [RULE_12]
          last = (idx_q == `JTP_IPG_LEN - 1'b1);
        end
      endcase
    end
  end

  // Mode is only taken while stopped, so a pattern never changes mid-stream
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      run_q <= 1'b0;
      mode_q <= JTP_MODE_HIGH;
    end else begin
      run_q <= run;
      if (!run_q) begin
        mode_q <= mode;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_pos_q <= 1'b0;
    end else if (!run_q) begin
      rd_pos_q <= 1'b0;
    end else if (take && gen_word.is_cg && jtp_unbalanced(gen_word.code_group)) begin
      rd_pos_q <= !rd_pos_q; // [RULE_03]
    end
  end

  // Packet sequencer: preamble, payload, CRC, gap, and round again [RULE_05] [RULE_06]
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= JTP_ST_PRE;
      idx_q <= '0;
      seq_q <= '0;
    end else if (!run_q) begin
      state_q <= JTP_ST_PRE;
      idx_q <= '0;
      seq_q <= '0;
    end else if (take && mode_q == JTP_MODE_LONG) begin
      idx_q <= last ? 11'h000 : idx_q + 1'b1;
      if (state_q == JTP_ST_PAY) begin
        seq_q <= (seq_q == `JTP_SEQ_LEN - 1'b1) ? 4'h0 : seq_q + 1'b1;
      end
      if (last) begin
        seq_q <= '0;
        case (state_q)
          JTP_ST_PRE: state_q <= JTP_ST_PAY;
          JTP_ST_PAY: state_q <= JTP_ST_CRC;
          JTP_ST_CRC: state_q <= JTP_ST_IPG;
          default: state_q <= JTP_ST_PRE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Buffer and output stage
  // ----------------------------------------------------------------
  logic fifo_valid;
  jtp_word_t fifo_word;
  logic fifo_pop;

  assign fifo_pop = fifo_valid && (!tx_valid_q || tx_ready);

  jtp_fifo #(
    .WIDTH($bits(jtp_word_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(run_q),
    .in_ready(gen_ready),
    .in_data(gen_word),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_word)
  );

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tx_valid_q <= 1'b0;
      tx_word_q <= '0;
    end else if (!tx_valid_q || tx_ready) begin
      tx_valid_q <= fifo_valid;
      if (fifo_valid) begin
        tx_word_q <= fifo_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive check
  // ----------------------------------------------------------------
  // Either disparity form is accepted; a slip shows as an illegal group
  logic rx_bad;
  assign rx_bad = rx_cg_valid && run_q && (mode_q != JTP_MODE_LONG) &&
                  (rx_cg != jtp_cg_pick(mode_q, 1'b0)) &&
                  (rx_cg != jtp_cg_pick(mode_q, 1'b1));

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      err_count_q <= `JTP_RST_ERR_COUNT;
      err_seen_q <= 1'b0;
    end else if (rx_bad) begin
      err_seen_q <= 1'b1; // [RULE_11]
      if (err_count_q != 16'hFFFF) begin
        err_count_q <= err_count_q + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  chk_low_group: assert property (take && mode_q == JTP_MODE_LOW |-> // [RULE_02]
    gen_word.code_group == `JTP_K28_7_NEG && gen_word.is_cg)
    else $error("low mode group wrong");
  chk_low_runlength: assert property (take && mode_q == JTP_MODE_LOW |-> // [RULE_01]
    gen_word.code_group[7:3] == 5'h1F && gen_word.code_group[2:0] == 3'h0)
    else $error("low mode run length wrong");
  chk_mixed_alternate: assert property ($past(take && mode_q == JTP_MODE_MIXED) |-> // [RULE_03]
    gen_word.code_group != $past(gen_word.code_group))
    else $error("mixed mode disparity not alternating");
  chk_high_group: assert property (take && mode_q == JTP_MODE_HIGH |-> // [RULE_04]
    gen_word.code_group == `JTP_D21_5 && gen_word.is_cg)
    else $error("high mode group wrong");
  chk_preamble_octets: assert property (take && mode_q == JTP_MODE_LONG && // [RULE_07]
    state_q == JTP_ST_PRE |-> gen_word.octet == ((idx_q == 11'h007) ? 8'hD5 : 8'h55))
    else $error("preamble octet wrong");
  chk_payload_seq: assert property ($past(take && state_q == JTP_ST_PAY && // [RULE_08]
    mode_q == JTP_MODE_LONG && gen_word.octet == 8'h59) |->
    state_q == JTP_ST_CRC || gen_word.octet == 8'hBE)
    else $error("payload sequence does not wrap");
  chk_payload_length: assert property (take && state_q == JTP_ST_PAY && // [RULE_06]
    idx_q == PAY_LEN - 1'b1 |=> state_q == JTP_ST_CRC && idx_q == 11'h000)
    else $error("payload length wrong");
  chk_crc_octets: assert property (take && mode_q == JTP_MODE_LONG && // [RULE_13]
    state_q == JTP_ST_CRC && idx_q == 11'h000 |-> gen_word.octet == 8'h94)
    else $error("crc octet wrong");
  chk_gap_idle: assert property (mode_q == JTP_MODE_LONG && // [RULE_12]
    state_q == JTP_ST_IPG |-> !gen_word.tx_en && !gen_word.tx_er && gen_word.octet == 8'h00)
    else $error("gap not idle");
  chk_gap_to_preamble: assert property (take && state_q == JTP_ST_IPG && // [RULE_05]
    idx_q == 11'h00B |=> state_q == JTP_ST_PRE)
    else $error("gap length wrong");
  chk_rx_errors: assert property (rx_bad && err_count_q != 16'hFFFF |=> // [RULE_11]
    err_count_q == $past(err_count_q) + 16'h0001 && err_seen_q)
    else $error("error count not raised");

  cov_low_mode: cover property (take && mode_q == JTP_MODE_LOW);
  cov_mixed_mode: cover property (take && mode_q == JTP_MODE_MIXED && rd_pos_q);
  cov_packet_wrap: cover property (take && state_q == JTP_ST_IPG ##1 state_q == JTP_ST_PRE);
  cov_backpressure: cover property (tx_valid_q && !tx_ready && !gen_ready);

endmodule : jtp_gen

// File: jtp_sink.sv
// Purpose: Downstream transmit path model that accepts generator words
// Assumes: Words are taken at a rising edge with valid and ready both high
// Notes: Ready moves only after the falling edge, so the sampling edge is clean
`timescale 1ns/10ps
module jtp_sink import jtp_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Stream from generator
  input wire jtp_word_t tx_word_q,
  input wire logic tx_valid_q,
  output logic tx_ready,
  // Pacing set by the bench
  input wire logic stall,
  input wire logic slow
);
  jtp_word_t words[$];
  logic [1:0] pace_q;

  // --------------------------------------------------------------
  // Pacing: slow accepts one cycle in four, like a busy encoder
  // --------------------------------------------------------------
  always @(negedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pace_q <= 2'h0;
      tx_ready <= 1'b0;
    end else begin
      pace_q <= pace_q + 2'h1;
      tx_ready <= !stall && (!slow || pace_q == 2'h0);
    end
  end

  always @(posedge clock) begin
    if (rst_n && tx_valid_q && tx_ready) begin
      words.push_back(tx_word_q);
    end
  end
endmodule : jtp_sink

// File: jtp_gen_tb.sv
// Purpose: Self-checking bench for the jitter test pattern generator
// Assumes: Inputs change on the falling edge only
// Notes: Long mode runs at full payload length, two packets and a bit
`timescale 1ns/10ps
`include "jtp_regs.svh"
module jtp_gen_tb import jtp_pkg::*; ;
  logic clock;
  logic rst_n;
  logic run;
  jtp_mode_t mode;
  jtp_word_t tx_word_q;
  logic tx_valid_q;
  logic tx_ready;
  logic rx_cg_valid;
  logic [9:0] rx_cg;
  logic [15:0] err_count_q;
  logic err_seen_q;
  logic stall;
  logic slow;
  int fail_count = 0;
  int num_checks = 0;
  localparam logic [7:0] SEQ [12] = '{8'hBE, 8'hD7, 8'h23, 8'h47, 8'h6B, 8'h8F,
                                      8'hB3, 8'h14, 8'h5E, 8'hFB, 8'h35, 8'h59};

  jtp_gen jtp_gen_i (.clock(clock), .rst_n(rst_n), .run(run), .mode(mode),
    .tx_word_q(tx_word_q), .tx_valid_q(tx_valid_q), .tx_ready(tx_ready),
    .rx_cg_valid(rx_cg_valid), .rx_cg(rx_cg), .err_count_q(err_count_q),
    .err_seen_q(err_seen_q));
  jtp_sink jtp_sink_i (.clock(clock), .rst_n(rst_n), .tx_word_q(tx_word_q),
    .tx_valid_q(tx_valid_q), .tx_ready(tx_ready), .stall(stall), .slow(slow));

  always #25 clock = ~clock;

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  task automatic check(string name, logic [20:0] seen, logic [20:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wait_words(int n);
    int i;
    for (i = 0; i < 20000 && jtp_sink_i.words.size() < n; i++) @(negedge clock);
    if (jtp_sink_i.words.size() < n) begin
      fail_count++;
      summarize();
    end
  endtask : wait_words

  // Stop, let the FIFO drain, then start afresh so disparity restarts
  task automatic start(jtp_mode_t m);
    @(negedge clock);
    run <= 1'b0;
    repeat (20) @(negedge clock);
    jtp_sink_i.words.delete();
    mode <= m;
    @(negedge clock);
    run <= 1'b1;
  endtask : start

  task automatic send(logic [9:0] v);
    @(negedge clock);
    rx_cg_valid <= 1'b1;
    rx_cg <= v;
    @(negedge clock);
    rx_cg_valid <= 1'b0;
  endtask : send

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic tone(jtp_mode_t m, logic [9:0] a, logic [9:0] b);
    int i;
    start(m);
    wait_words(16);
    for (i = 0; i < 16; i++) begin
      check("tone", jtp_sink_i.words[i],
            {11'h400, (i % 2 == 0) ? a : b});
    end
  endtask : tone

  task automatic long_run();
    logic [10:0] exp[$];
    jtp_word_t w;
    int p;
    int k;
    for (p = 0; p < 3; p++) begin
      for (k = 0; k < 7; k++) exp.push_back({3'b010, `JTP_PRE_OCTET});
      exp.push_back({3'b010, `JTP_SFD_OCTET});
      for (k = 0; k < 1512; k++) exp.push_back({3'b010, SEQ[k % 12]});
      exp.push_back({3'b010, `JTP_CRC0});
      exp.push_back({3'b010, `JTP_CRC1});
      exp.push_back({3'b010, `JTP_CRC2});
      exp.push_back({3'b010, `JTP_CRC3});
      for (k = 0; k < 12; k++) exp.push_back(11'h000);
    end
    start(JTP_MODE_LONG);
    stall <= 1'b1;
    repeat (30) @(negedge clock);
    check("held", {20'h0, tx_valid_q}, 21'h1);
    check("taken", 21'(jtp_sink_i.words.size()), 21'h0);
    stall <= 1'b0;
    slow <= 1'b1;
    repeat (400) @(negedge clock);
    slow <= 1'b0;
    wait_words(2 * 1536 + 8);
    for (k = 0; k < 2 * 1536 + 8; k++) begin
      w = jtp_sink_i.words[k];
      check("long", w,
            {exp[k], 10'h000});
    end
  endtask : long_run

  task automatic rx_run();
    start(JTP_MODE_LOW);
    repeat (5) @(negedge clock);
    send(`JTP_K28_7_NEG);
    send(`JTP_K28_7_POS);
    check("clean", {5'h0, err_count_q}, 21'h0);
    send(10'h000);
    check("count", {5'h0, err_count_q}, 21'h1);
    check("seen", {20'h0, err_seen_q}, 21'h1);
    start(JTP_MODE_LONG);
    send(10'h000);
    run <= 1'b0;
    repeat (3) @(negedge clock);
    send(10'h000);
    check("ignored", {5'h0, err_count_q}, 21'h1);
  endtask : rx_run

  initial begin
    clock = 1'b0;
    rst_n = 1'b0;
    run = 1'b0;
    mode = JTP_MODE_HIGH;
    rx_cg_valid = 1'b0;
    rx_cg = 10'h000;
    stall = 1'b0;
    slow = 1'b0;
    repeat (20) @(negedge clock);
    check("rst_valid", {20'h0, tx_valid_q}, 21'h0);
    check("rst_word", tx_word_q, 21'h0);
    check("rst_err", {4'h0, err_seen_q, err_count_q}, 21'h0);
    rst_n <= 1'b1;
    tone(JTP_MODE_LOW, `JTP_K28_7_NEG, `JTP_K28_7_NEG);
    tone(JTP_MODE_MIXED, `JTP_K28_5_NEG, `JTP_K28_5_POS);
    tone(JTP_MODE_HIGH, `JTP_D21_5, `JTP_D21_5);
    long_run();
    rx_run();
    summarize();
  end
endmodule : jtp_gen_tb
